//--- logic/psc_strap_config.sv
/*
 power-on strap configuration loader: latches straps at reset release, holds a
 shadow with override select, decodes settings, fetches subsystem IDs from ROM.
 assumes strap pins and ROM data synchronous to core_clk; ROM answers next cycle.
*/
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module psc_strap_config
    import psc_pkg::*;
#(
    parameter logic [15:0] CHIP_ID_LEGACY = 16'h0a00, // arbitrary value
    parameter logic [15:0] CHIP_ID_POWER  = 16'h0a01  // arbitrary value
)(
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic [STRAP_WIDTH-1:0] strap_pins,
    input  wire logic [23:0]            regAddr,
    input  wire logic [31:0]            regWrData,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [31:0]            regRdData,
    output logic      [23:0]            romAddr,
    output logic                        romRd,
    input  wire logic [7:0]             romData,
    output logic                        sysBusEnable,
    output logic                        agpDoubleRate,
    output logic                        hostIsAgp,
    output logic      [1:0]             tvMode,
    output logic                        refClock14m,
    output logic                        fbUpperEnable,
    output logic                        powerMgmtPresent,
    output logic      [15:0]            chip_identifier,
    output logic                        memType8m,
    output logic      [31:0]            subsysIds,
    output logic                        subsysWritable,
    output logic                        busSpeed66
);
    // the field layout below is fixed at ten straps
    if (STRAP_WIDTH != 10) begin : g_width_check
        $error("strap width must be 10");
    end

    logic [STRAP_WIDTH-1:0] strapLatch;
    logic [STRAP_WIDTH-1:0] shadow;
    logic                   overrideSel;
    logic [31:0]            subsys;
    logic [7:0]             fetchCount;
    logic                   fetchPending;
    psc_state_type          state;
    psc_decode_if           dif ();

    // R15 - decoded outputs only ever see the selected source
    assign dif.strapWord = overrideSel ? shadow : strapLatch; // R12

    psc_strap_decode u_decode (
        .dif (dif)
    );

    // R11 - catch straps at the first clock after release; no async load from pins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state        <= PSC_WAIT_RELEASE;
            strapLatch   <= SHADOW_RESET;
            fetchCount   <= 8'h00;
            fetchPending <= 1'b0;
        end else begin
            fetchPending <= 1'b0;
            case (state)
                PSC_WAIT_RELEASE: begin
                    strapLatch <= strap_pins; // R11
                    state      <= strap_pins[SUBSYS_SRC_BIT] ? PSC_ROM_FETCH : PSC_RUNNING;
                end
                PSC_ROM_FETCH: begin // R8
                    // strobe and capture alternate, so each byte takes two cycles
                    if (!fetchPending) begin
                        fetchPending <= 1'b1;
                    end else if (fetchCount == ROM_LOAD_BYTES - 8'h01) begin
                        state        <= PSC_RUNNING;
                    end else begin
                        fetchCount   <= fetchCount + 8'h01;
                    end
                end
                PSC_RUNNING: ; // R15
                default: state <= PSC_WAIT_RELEASE;
            endcase
        end
    end

    assign romRd        = (state == PSC_ROM_FETCH) && !fetchPending;
    assign romAddr      = ROM_SUBSYS_LO + {16'h0000, fetchCount};
    assign sysBusEnable = (state != PSC_WAIT_RELEASE); // R11

    // shadow register and override select
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shadow      <= SHADOW_RESET;
            overrideSel <= 1'b0;
        end else if (regWr && regAddr == BOOT_CFG_ADDR && sysBusEnable) begin
            shadow      <= regWrData[STRAP_WIDTH-1:0]; // R13
            overrideSel <= regWrData[OVERRIDE_BIT];    // R12
        end
    end

    // subsystem IDs: zero and writable, or loaded byte by byte from ROM
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            subsys <= SUBSYS_RESET;
        end else if (state == PSC_ROM_FETCH && fetchPending) begin
            subsys <= {romData, subsys[31:8]}; // R8
        end else if (regWr && regAddr == SUBSYS_ADDR && state == PSC_RUNNING
                     && !dif.subsysFromRom) begin
            subsys <= regWrData; // R7 R9
        end
    end

    // read port: data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                BOOT_CFG_ADDR: regRdData <= {20'h00000, overrideSel, 1'b0, dif.strapWord}; // R14
                SUBSYS_ADDR:   regRdData <= subsysIds;
                default:       regRdData <= 32'h00000000;
            endcase
        end else begin
            regRdData <= 32'h00000000;
        end
    end

    assign agpDoubleRate    = dif.agpDoubleRate;                  // R1
    assign hostIsAgp        = dif.hostIsAgp;                      // R1
    assign tvMode           = dif.tvMode;                         // R2
    assign refClock14m      = dif.refClock14m;                    // R3
    assign fbUpperEnable    = dif.wideFrameBuffer;                // R4
    assign powerMgmtPresent = dif.powerMgmtPresent;               // R5
    assign chip_identifier  = dif.powerMgmtPresent ? CHIP_ID_POWER : CHIP_ID_LEGACY; // R5
    assign memType8m        = dif.memType8m;                      // R6
    // firmware source shows zero until PSC_RUNNING, then the stored word; ROM source shows the word as it fills
    assign subsysIds        = dif.subsysFromRom ? subsys : (state == PSC_RUNNING ? subsys
                                                              : SUBSYS_RESET); // R7
    assign subsysWritable   = !dif.subsysFromRom;                 // R7
    assign busSpeed66       = dif.busSpeed66;                     // R10

    property p_latch_hold;
        @(posedge core_clk) disable iff (!arst_n)
        (state == PSC_RUNNING) |=> $stable(strapLatch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("strap latch changed"); // R15

    property p_bus_float;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(sysBusEnable) |-> $past(state) == PSC_WAIT_RELEASE
            && strapLatch == $past(strap_pins);
    endproperty
    a_bus_float: assert property (p_bus_float) else $error("bus driven before capture"); // R11

    property p_select;
        @(posedge core_clk) disable iff (!arst_n)
        dif.strapWord == (overrideSel ? shadow : strapLatch);
    endproperty
    a_select: assert property (p_select) else $error("wrong strap source"); // R12

    property p_write_shadow;
        @(posedge core_clk) disable iff (!arst_n)
        (regWr && regAddr == BOOT_CFG_ADDR && sysBusEnable)
            |=> shadow == $past(regWrData[9:0]) && $stable(strapLatch);
    endproperty
    a_write_shadow: assert property (p_write_shadow) else $error("shadow write lost"); // R13

    property p_read_boot;
        @(posedge core_clk) disable iff (!arst_n)
        (regRd && regAddr == BOOT_CFG_ADDR) |=> regRdData[9:0] == $past(dif.strapWord);
    endproperty
    a_read_boot: assert property (p_read_boot) else $error("boot read wrong"); // R14

    property p_agp_rate;
        @(posedge core_clk) disable iff (!arst_n)
        agpDoubleRate != dif.strapWord[9] && hostIsAgp == dif.strapWord[5];
    endproperty
    a_agp_rate: assert property (p_agp_rate) else $error("port mode decode wrong"); // R1

    property p_tv;
        @(posedge core_clk) disable iff (!arst_n)
        tvMode == dif.strapWord[8:7] && refClock14m == dif.strapWord[6];
    endproperty
    a_tv: assert property (p_tv) else $error("tv or clock decode wrong"); // R2 R3

    property p_width;
        @(posedge core_clk) disable iff (!arst_n)
        fbUpperEnable == dif.strapWord[4] && memType8m == dif.strapWord[2];
    endproperty
    a_width: assert property (p_width) else $error("memory decode wrong"); // R4 R6

    property p_chip_id;
        @(posedge core_clk) disable iff (!arst_n)
        chip_identifier == (dif.strapWord[3] ? CHIP_ID_POWER : CHIP_ID_LEGACY);
    endproperty
    a_chip_id: assert property (p_chip_id) else $error("chip identifier wrong"); // R5

    property p_subsys_zero;
        @(posedge core_clk) disable iff (!arst_n)
        (state == PSC_WAIT_RELEASE) ##1 !dif.subsysFromRom |-> subsysIds == 32'h00000000;
    endproperty
    a_subsys_zero: assert property (p_subsys_zero) else $error("subsystem not zero"); // R7

    property p_rom_fetch;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(state == PSC_ROM_FETCH) |-> ##[1:9] (state == PSC_RUNNING);
    endproperty
    a_rom_fetch: assert property (p_rom_fetch) else $error("rom fetch stuck"); // R8

    property p_speed;
        @(posedge core_clk) disable iff (!arst_n)
        busSpeed66 == dif.strapWord[0];
    endproperty
    a_speed: assert property (p_speed) else $error("bus speed bit wrong"); // R10

    property p_rom_strobe;
        @(posedge core_clk) disable iff (!arst_n)
        romRd |-> (romAddr >= ROM_SUBSYS_LO && romAddr <= ROM_SUBSYS_HI) ##1 !romRd;
    endproperty
    a_rom_strobe: assert property (p_rom_strobe) else $error("rom strobe wrong"); // R8

    property p_subsys_write;
        @(posedge core_clk) disable iff (!arst_n)
        (regWr && regAddr == SUBSYS_ADDR && state == PSC_RUNNING && !dif.subsysFromRom)
            |=> subsysIds == $past(regWrData);
    endproperty
    a_subsys_write: assert property (p_subsys_write) else $error("subsystem write lost"); // R7
endmodule : psc_strap_config

//--- logic/psc_pkg.sv
/*
 power-on strap configuration package: register offsets, strap field layout,
 reset values and decoded setting types.
 assumes a plain register port with read data one cycle after the read strobe.
*/
// How it works
// R1 - strap 9 low enables double-rate port mode; strap 5 picks PCI or graphics port
// R2 - strap 8:7 picks TV standard: 01 NTSC, 10 PAL, 11 off, 00 reserved
// R3 - strap 6 reports reference clock: 0 is 13.5MHz, 1 is 14.31818MHz
// R4 - strap 4 low gives 64-bit framebuffer, upper half tristated; high gives 128-bit
// R5 - strap 3 high makes power registers present and picks the second chip identifier
// R6 - strap 2 picks memory type: 0 is 16Mbit parts, 1 is 8Mbit two-bank
// R7 - strap 1 low gives subsystem IDs of zero, writable by firmware
// R8 - strap 1 high loads subsystem IDs from boot ROM bytes 0x54 to 0x57
// R9 - firmware must write subsystem IDs before enumeration runs
// R10 - strap 0 drives the 66MHz-capable configuration bit
// R11 - straps are caught at reset release; system bus floats until then
// R12 - shadow register mirrors straps; bit 11 selects shadow over latches; here the shadow resets to zero, loaded only by writes
// R13 - writing boot configuration updates the shadow only
// R14 - reading boot configuration returns the selected source
// R15 - latched straps hold until next reset; settings follow the selected source
package psc_pkg;
    localparam int          STRAP_WIDTH      = 10;
    localparam logic [23:0] BOOT_CFG_ADDR    = 24'h101000;
    localparam logic [23:0] SUBSYS_ADDR      = 24'h101004;
    localparam logic [23:0] ROM_SUBSYS_LO    = 24'h000054;
    localparam logic [23:0] ROM_SUBSYS_HI    = 24'h000057;
    localparam int          OVERRIDE_BIT     = 11;
    localparam int          AGP_RATE_BIT     = 9;
    localparam int          TV_HI_BIT        = 8;
    localparam int          TV_LO_BIT        = 7;
    localparam int          CRYSTAL_BIT      = 6;
    localparam int          HOST_IF_BIT      = 5;
    localparam int          RAM_WIDTH_BIT    = 4;
    localparam int          PWR_MGMT_BIT     = 3;
    localparam int          RAM_TYPE_BIT     = 2;
    localparam int          SUBSYS_SRC_BIT   = 1;
    localparam int          BUS_SPEED_BIT    = 0;
    localparam logic [9:0]  SHADOW_RESET     = 10'h000;
    localparam logic [31:0] SUBSYS_RESET     = 32'h00000000;
    localparam logic [7:0]  ROM_LOAD_BYTES   = 8'h04;

    typedef enum logic [1:0] {
        PSC_TV_RESERVED = 2'b00,
        PSC_TV_NTSC     = 2'b01,
        PSC_TV_PAL      = 2'b10,
        PSC_TV_OFF      = 2'b11
    } psc_tv_type;

    typedef enum logic [1:0] {
        PSC_WAIT_RELEASE = 2'b00,
        PSC_ROM_FETCH    = 2'b01,
        PSC_RUNNING      = 2'b10
    } psc_state_type;
endpackage : psc_pkg

//--- logic/psc_decode_if.sv
/*
 interface carrying the selected strap word and its decoded settings.
 assumes one clock domain; the top module drives the strap word, the decoder drives the settings.
*/
`timescale 1ns/1ns
interface psc_decode_if;
    import psc_pkg::*;
    logic [STRAP_WIDTH-1:0] strapWord;
    logic                   agpDoubleRate;
    logic                   hostIsAgp;
    psc_tv_type             tvMode;
    logic                   refClock14m;
    logic                   wideFrameBuffer;
    logic                   powerMgmtPresent;
    logic                   memType8m;
    logic                   subsysFromRom;
    logic                   busSpeed66;
    modport dec (input strapWord, output agpDoubleRate, hostIsAgp, tvMode, refClock14m,
                 wideFrameBuffer, powerMgmtPresent, memType8m, subsysFromRom, busSpeed66);
    modport use_side (input strapWord, agpDoubleRate, hostIsAgp, tvMode, refClock14m,
                      wideFrameBuffer, powerMgmtPresent, memType8m, subsysFromRom,
                      busSpeed66);
endinterface : psc_decode_if

//--- logic/psc_strap_decode.sv
/*
 decodes the selected strap word into individual settings.
 assumes the word is already the selected source.
*/
`timescale 1ns/1ns
module psc_strap_decode
    import psc_pkg::*;
(
    psc_decode_if.dec dif
);
    assign dif.agpDoubleRate    = ~dif.strapWord[AGP_RATE_BIT];             // R1
    assign dif.hostIsAgp        = dif.strapWord[HOST_IF_BIT];               // R1
    assign dif.tvMode           = psc_tv_type'(dif.strapWord[TV_HI_BIT:TV_LO_BIT]); // R2
    assign dif.refClock14m      = dif.strapWord[CRYSTAL_BIT];               // R3
    assign dif.wideFrameBuffer  = dif.strapWord[RAM_WIDTH_BIT];             // R4
    assign dif.powerMgmtPresent = dif.strapWord[PWR_MGMT_BIT];              // R5
    assign dif.memType8m        = dif.strapWord[RAM_TYPE_BIT];              // R6
    assign dif.subsysFromRom    = dif.strapWord[SUBSYS_SRC_BIT];            // R7 R8
    assign dif.busSpeed66       = dif.strapWord[BUS_SPEED_BIT];             // R10
endmodule : psc_strap_decode

//--- verification/psc_rom_model.sv
/*
 behavioural boot ROM holding the four subsystem identifier bytes.
 assumes the loader strobes one byte address at a time and samples the byte
 in the cycle after the strobe.
*/
`timescale 1ns/1ns
module psc_rom_model
    import psc_pkg::*;
#(
    parameter logic [31:0] ROM_IDS = 32'h5a3c9617
)(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [23:0] romAddr,
    input  wire logic        romRd,
    output logic      [7:0]  romData
);
    // between reads the byte lines toggle, so a late or early sample cannot pass by luck
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            romData <= 8'h00;
        end else if (romRd && romAddr >= ROM_SUBSYS_LO && romAddr <= ROM_SUBSYS_HI) begin
            romData <= ROM_IDS[8*romAddr[1:0] +: 8];
        end else begin
            romData <= ~romData;
        end
    end
endmodule : psc_rom_model

//--- verification/psc_strap_config_tb.sv
/*
 self-checking bench for the strap configuration loader.
 assumes the behavioural ROM model answers one cycle after its read strobe.
*/
`timescale 1ns/1ns
module psc_strap_config_tb;
    import psc_pkg::*;
    localparam logic [15:0] ID_OLD  = 16'h0a00; // arbitrary value
    localparam logic [15:0] ID_NEW  = 16'h0a01; // arbitrary value
    localparam logic [31:0] ROM_IDS = 32'h5a3c9617;
    logic        core_clk   = 1'b0;
    logic        arst_n     = 1'b0;
    logic [9:0]  strap_pins = 10'h000;
    logic [23:0] regAddr    = 24'h000000;
    logic [31:0] regWrData  = 32'h00000000;
    logic        regWr      = 1'b0;
    logic        regRd      = 1'b0;
    logic [31:0] regRdData, subsysIds, rdv;
    logic [23:0] romAddr;
    logic [7:0]  romData;
    logic [15:0] chip_identifier;
    logic [1:0]  tvMode;
    logic        romRd, sysBusEnable, agpDoubleRate, hostIsAgp, refClock14m;
    logic        fbUpperEnable, powerMgmtPresent, memType8m, subsysWritable, busSpeed66;
    // together these cover every TV code and both values of every strap
    logic [9:0]  words [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
    int          fail_count = 0;
    int          checked    = 0;
    int          cycles     = 0;

    psc_strap_config #(.CHIP_ID_LEGACY(ID_OLD), .CHIP_ID_POWER(ID_NEW)) i_psc_strap_config (
        .core_clk, .arst_n, .strap_pins, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .romAddr, .romRd, .romData, .sysBusEnable, .agpDoubleRate,
        .hostIsAgp, .tvMode, .refClock14m, .fbUpperEnable, .powerMgmtPresent,
        .chip_identifier, .memType8m, .subsysIds, .subsysWritable, .busSpeed66);
    psc_rom_model #(.ROM_IDS(ROM_IDS)) i_psc_rom_model (
        .core_clk, .arst_n, .romAddr, .romRd, .romData);

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // the whole run needs about 150 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [23:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    task automatic chk_settings(input logic [9:0] w);
        chk(32'(agpDoubleRate), 32'(!w[9]));
        chk(32'(hostIsAgp), 32'(w[5]));
        chk(32'(tvMode), 32'(w[8:7]));
        chk(32'(refClock14m), 32'(w[6]));
        chk(32'(fbUpperEnable), 32'(w[4]));
        chk(32'(powerMgmtPresent), 32'(w[3]));
        chk(32'(chip_identifier), 32'(w[3] ? ID_NEW : ID_OLD));
        chk(32'(memType8m), 32'(w[2]));
        chk(32'(subsysWritable), 32'(!w[1]));
        chk(32'(busSpeed66), 32'(w[0]));
    endtask : chk_settings

    initial begin
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            arst_n     <= 1'b0;
            strap_pins <= words[i];
            repeat (5) @(posedge core_clk);
            #1;
            chk(32'(sysBusEnable), 32'h0);
            chk(32'(agpDoubleRate), 32'h1);
            @(posedge core_clk);
            arst_n <= 1'b1;
            repeat (2) @(posedge core_clk);
            // pins move after capture; the latched word must not follow
            strap_pins <= ~words[i];
            #1;
            chk(32'(sysBusEnable), 32'h1);
            repeat (12) @(posedge core_clk);
            #1;
            chk_settings(words[i]);
            chk(subsysIds, words[i][1] ? ROM_IDS : SUBSYS_RESET);
            rd(BOOT_CFG_ADDR, rdv);
            chk(rdv, {22'h0, words[i]});
            // firmware fills the subsystem IDs before enumeration
            wr(SUBSYS_ADDR, 32'hc3a51e0f);
            @(posedge core_clk);
            #1;
            chk(subsysIds, words[i][1] ? ROM_IDS : 32'hc3a51e0f);
            rd(SUBSYS_ADDR, rdv);
            chk(rdv, words[i][1] ? ROM_IDS : 32'hc3a51e0f);
            wr(BOOT_CFG_ADDR, {20'h0, 2'b10, ~words[i]});
            #1;
            chk_settings(~words[i]);
            rd(BOOT_CFG_ADDR, rdv);
            chk(rdv, {20'h0, 2'b10, ~words[i]});
            rd(24'h101008, rdv);
            chk(rdv, 32'h0);
            wr(BOOT_CFG_ADDR, 32'h0);
            rd(BOOT_CFG_ADDR, rdv);
            chk(rdv, {22'h0, words[i]});
            chk_settings(words[i]);
        end
        report_and_stop();
    end
endmodule : psc_strap_config_tb
